/* File: bench/host_model.sv */
// host side model: issues the flag clear write strobe and holds the recovery bit for an inrush window
// assumes requests from the bench are sampled on the rising edge of clock
`timescale 1ns/1ns
module host_model #(
   parameter int inrush_cycles = 12
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clear_req,
   input wire logic recover_req,
   output logic flag_clear_bit,
   output logic clear_strobe,
   output logic recovery_ctrl
);
   int hold_q;
   logic clr_s;
   logic rec_s;
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         hold_q = 0;
         flag_clear_bit = 1'h0;
         clear_strobe = 1'h0;
         recovery_ctrl = 1'h0;
      end else begin
         // sample first so the bench may change requests in the same step as our update
         clr_s = clear_req;
         rec_s = recover_req;
         #1;
         flag_clear_bit = clr_s;
         clear_strobe = clr_s;
         if (rec_s) hold_q = inrush_cycles;
         else if (hold_q > 0) hold_q--;
         recovery_ctrl = (hold_q > 0);
      end
   end
endmodule : host_model

/* File: bench/tb_top.sv */
// self-checking bench for output_protection_diag
// assumes levels are sampled each rising edge and outputs answer one edge later
`timescale 1ns/1ns
module tb_top;
   logic clock, sys_rst, reset_condition, strong_hs_ctrl, lin_tx_ctrl, recovery_ctrl, flag_clear_bit;
   logic clear_strobe, watchdog_fail, watchdog_kick_missing, watchdog_fail_event, watchdog_kick_bit;
   logic main_regulator_restart_fail, status_kick_q, global_error, clear_req, recover_req, active_mode;
   logic [3:0] small_hs_ctrl;
   logic [1:0] relay_ctrl;
   logic [7:0] control_reg_two;
   logic [2:0] restart_fail_count, wd_fail_count;
   prot_diag_pkg::fault_in_t faults;
   prot_diag_pkg::drive_t drive;
   prot_diag_pkg::diag_flags_t diag_flags;
   int n_fail = 0;
   int comparisons = 0;

   output_protection_diag i_dut (.clock(clock), .sys_rst(sys_rst), .faults(faults), .active_mode(active_mode),
      .reset_condition(reset_condition), .small_hs_ctrl(small_hs_ctrl), .strong_hs_ctrl(strong_hs_ctrl),
      .relay_ctrl(relay_ctrl), .lin_tx_ctrl(lin_tx_ctrl), .control_reg_two(control_reg_two),
      .recovery_ctrl(recovery_ctrl), .flag_clear_bit(flag_clear_bit), .clear_strobe(clear_strobe),
      .watchdog_fail(watchdog_fail), .watchdog_kick_missing(watchdog_kick_missing),
      .watchdog_fail_event(watchdog_fail_event), .watchdog_kick_bit(watchdog_kick_bit),
      .main_regulator_restart_fail(main_regulator_restart_fail), .drive(drive), .diag_flags(diag_flags),
      .status_kick_q(status_kick_q), .restart_fail_count(restart_fail_count), .wd_fail_count(wd_fail_count),
      .global_error(global_error));
   host_model #(.inrush_cycles(12)) i_host (.clock(clock), .sys_rst(sys_rst), .clear_req(clear_req),
      .recover_req(recover_req), .flag_clear_bit(flag_clear_bit), .clear_strobe(clear_strobe),
      .recovery_ctrl(recovery_ctrl));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic do_clear;
      clear_req = 1'h1;
      step(1);
      clear_req = 1'h0;
      step(1);
   endtask : do_clear
   task automatic pulses(ref logic s);
      for (int i = 0; i < 9; i++) begin
         s = 1'h1;
         step(1);
         s = 1'h0;
         step(1);
      end
   endtask : pulses
   task automatic stop_test;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_supply;
      faults.supply_ov = 1'h1;
      step(1);
      chk("drive_ov", 8'h00, drive);
      chk("ov_flag", 1'h1, diag_flags.supply_ov);
      step(1);
      chk("global_error", 1'h1, global_error);
      faults.supply_ov = 1'h0;
      step(3);
      chk("drive_ov_held", 8'h00, drive);
      chk("ov_flag_kept", 1'h1, diag_flags.supply_ov);
      do_clear();
      chk("ov_flag_clr", 1'h0, diag_flags.supply_ov);
      step(1);
      chk("drive_back", 8'hff, drive);
      chk("global_error_clr", 1'h0, global_error);
      control_reg_two = 8'h01 << prot_diag_pkg::auto_recovery_bit;
      faults.supply_uv = 1'h1;
      step(1);
      chk("drive_uv", 8'h00, drive);
      chk("uv_flag", 1'h1, diag_flags.supply_uv);
      faults.supply_uv = 1'h0;
      // the supply hold register lets go one edge after the fault ends
      step(2);
      chk("drive_auto", 8'hff, drive);
      do_clear();
      control_reg_two = 8'h00;
      $display("test supply done");
   endtask : t_supply
   task automatic t_overcurrent;
      recover_req = 1'h1;
      step(1);
      recover_req = 1'h0;
      step(1);
      faults.strong_oc = 1'h1;
      step(1);
      chk("strong_off", 1'h0, drive.strong_hs_en);
      chk("strong_oc_flag", 1'h1, diag_flags.strong_oc);
      faults.strong_oc = 1'h0;
      step(1);
      chk("strong_restart", 1'h1, drive.strong_hs_en);
      active_mode = 1'h0;
      faults.strong_oc = 1'h1;
      step(1);
      faults.strong_oc = 1'h0;
      step(2);
      chk("strong_no_active", 1'h0, drive.strong_hs_en);
      active_mode = 1'h1;
      step(12);
      faults.strong_oc = 1'h1;
      step(1);
      faults.strong_oc = 1'h0;
      step(3);
      chk("strong_kept_off", 1'h0, drive.strong_hs_en);
      faults.small_oc = 4'h2;
      faults.small_ol = 4'h4;
      faults.strong_ol = 1'h1;
      step(1);
      faults.small_oc = 4'h0;
      faults.small_ol = 4'h0;
      faults.strong_ol = 1'h0;
      chk("small_off", 4'hd, drive.small_hs_en);
      chk("strong_ol_flag", 1'h1, diag_flags.strong_ol);
      chk("small_oc_flag", 4'h2, diag_flags.small_oc);
      chk("small_ol_flag", 4'h4, diag_flags.small_ol);
      strong_hs_ctrl = 1'h0;
      small_hs_ctrl = 4'h0;
      step(1);
      strong_hs_ctrl = 1'h1;
      small_hs_ctrl = 4'hf;
      do_clear();
      chk("drive_rearm", 8'hff, drive);
      $display("test overcurrent done");
   endtask : t_overcurrent
   task automatic t_shutdown;
      for (int i = 0; i < 3; i++) begin
         {faults.thermal_one, faults.thermal_two, reset_condition} = 3'h4 >> i;
         step(1);
         chk("hs_disabled", 5'h00, {drive.small_hs_en, drive.strong_hs_en});
      end
      reset_condition = 1'h0;
      watchdog_fail = 1'h1;
      step(1);
      chk("wd_drivers_off", 7'h00, {drive.small_hs_en, drive.strong_hs_en, drive.relay_en});
      pulses(watchdog_fail_event);
      chk("wd_count_sat", 3'h7, wd_fail_count);
      watchdog_fail = 1'h0;
      step(1);
      chk("wd_resume", 8'hff, drive);
      watchdog_kick_missing = 1'h1;
      step(1);
      chk("relay_off", 2'h0, drive.relay_en);
      watchdog_kick_missing = 1'h0;
      step(1);
      chk("wd_count_rst", 3'h0, wd_fail_count);
      $display("test shutdown done");
   endtask : t_shutdown
   task automatic t_status;
      watchdog_kick_bit = 1'h1;
      step(1);
      chk("kick_set", 1'h1, status_kick_q);
      watchdog_kick_bit = 1'h0;
      step(1);
      chk("kick_clr", 1'h0, status_kick_q);
      faults.main_reg_fail = 1'h1;
      step(1);
      faults.main_reg_fail = 1'h0;
      chk("global_reg_fail", 1'h1, global_error);
      step(1);
      chk("global_idle", 1'h0, global_error);
      pulses(main_regulator_restart_fail);
      chk("restart_sat", 3'h7, restart_fail_count);
      for (int i = 0; i < 3; i++) begin
         {faults.lin_short_gnd, faults.lin_short_bat, faults.lin_dom_timeout} = 3'h1 << i;
         step(1);
         faults.lin_short_gnd = 1'h0;
         faults.lin_short_bat = 1'h0;
         faults.lin_dom_timeout = 1'h0;
         chk("lin_flags", 3'h1 << i, {diag_flags.lin_short_gnd, diag_flags.lin_short_bat,
            diag_flags.lin_dom_timeout});
         do_clear();
      end
      $display("test status done");
   endtask : t_status

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (3000) @(posedge clock);
      n_fail++;
      stop_test();
   end
   initial begin
      sys_rst = 1'h1;
      faults = '0;
      {reset_condition, watchdog_fail, watchdog_kick_missing, watchdog_fail_event} = 4'h0;
      {watchdog_kick_bit, main_regulator_restart_fail, clear_req, recover_req} = 4'h0;
      control_reg_two = 8'h00;
      small_hs_ctrl = 4'hf;
      strong_hs_ctrl = 1'h1;
      relay_ctrl = 2'h3;
      lin_tx_ctrl = 1'h1;
      active_mode = 1'h1;
      repeat (3) @(posedge clock);
      #1 sys_rst = 1'h0;
      step(1);
      chk("restart_rst", 3'h0, restart_fail_count);
      step(1);
      t_supply();
      t_overcurrent();
      t_shutdown();
      t_status();
      stop_test();
   end
endmodule : tb_top

/* File: rtl/output_protection_diag.sv */
// protection and diagnosis logic: gates the output drivers on faults and latches diagnosis flags
// assumes all fault and control inputs are synchronous to clock (spi and comparators resynced upstream)
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module output_protection_diag (
   input wire logic clock,
   input wire logic sys_rst,
   input wire prot_diag_pkg::fault_in_t faults,
   input wire logic active_mode,
   input wire logic reset_condition,
   input wire logic [prot_diag_pkg::num_small_hs-1:0] small_hs_ctrl,
   input wire logic strong_hs_ctrl,
   input wire logic [1:0] relay_ctrl,
   input wire logic lin_tx_ctrl,
   input wire logic [7:0] control_reg_two,
   input wire logic recovery_ctrl,
   input wire logic flag_clear_bit,
   input wire logic clear_strobe,
   input wire logic watchdog_fail,
   input wire logic watchdog_kick_missing,
   input wire logic watchdog_fail_event,
   input wire logic watchdog_kick_bit,
   input wire logic main_regulator_restart_fail,
   output prot_diag_pkg::drive_t drive,
   output prot_diag_pkg::diag_flags_t diag_flags,
   output logic status_kick_q,
   output logic [prot_diag_pkg::restart_cnt_width-1:0] restart_fail_count,
   output logic [prot_diag_pkg::wd_fail_cnt_width-1:0] wd_fail_count,
   output logic global_error
);

   ////////////////////////////////////////////////////////////////////////////////
   // supply fault hold: without auto recovery the outputs stay off until a clear

   logic supply_hold_q;
   logic supply_hold_d;
   logic supply_fault;
   logic auto_recover;
   logic clear_now;

   assign supply_fault = faults.supply_ov | faults.supply_uv;
   assign auto_recover = control_reg_two[prot_diag_pkg::auto_recovery_bit];
   assign clear_now = clear_strobe & flag_clear_bit;
   // set wins over the clear in the same cycle
   assign supply_hold_d = supply_fault | (supply_hold_q & ~auto_recover & ~clear_now);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         supply_hold_q <= 1'b0;
      end else begin
         supply_hold_q <= supply_hold_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // over-current latches; the strong output may restart when recovery is set in active mode

   logic [prot_diag_pkg::num_small_hs-1:0] small_trip_q;
   logic [prot_diag_pkg::num_small_hs-1:0] small_trip_d;
   logic strong_trip_q;
   logic strong_trip_d;
   logic restart_ok;

   assign restart_ok = active_mode & recovery_ctrl;
   // a tripped small output stays off until its control bit is dropped
   assign small_trip_d = faults.small_oc | (small_trip_q & small_hs_ctrl);
   // with recovery set in active mode the trip does not latch past the fault input, so the stage retries;
   // without it the stage stays off while overload persists or ctrl is held
   assign strong_trip_d = faults.strong_oc | (strong_trip_q & strong_hs_ctrl & ~restart_ok);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         small_trip_q <= prot_diag_pkg::small_hs_off;
         strong_trip_q <= 1'b0;
      end else begin
         small_trip_q <= small_trip_d;
         strong_trip_q <= strong_trip_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // driver gating

   logic hs_block;
   logic relay_block;
   prot_diag_pkg::drive_t drive_d;

   assign hs_block = reset_condition | supply_fault | supply_hold_q | faults.thermal_one
      | faults.thermal_two | watchdog_fail;
   assign relay_block = supply_fault | supply_hold_q | watchdog_fail | watchdog_kick_missing;
   // control inputs are never touched here, so drivers resume once the block lifts
   assign drive_d.small_hs_en = small_hs_ctrl & ~small_trip_d & {prot_diag_pkg::num_small_hs{~hs_block}};
   assign drive_d.strong_hs_en = strong_hs_ctrl & ~strong_trip_d & ~hs_block;
   assign drive_d.relay_en = relay_ctrl & {2{~relay_block}};
   assign drive_d.lin_tx_en = lin_tx_ctrl & ~(supply_fault | supply_hold_q);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         drive <= '0;
      end else begin
         drive <= drive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // latched diagnosis flags, sticky until a clear write

   prot_diag_pkg::diag_flags_t flag_set;
   prot_diag_pkg::diag_flags_t flags_d;

   assign flag_set.supply_ov = faults.supply_ov;
   assign flag_set.supply_uv = faults.supply_uv;
   assign flag_set.small_oc = faults.small_oc;
   assign flag_set.strong_oc = faults.strong_oc;
   assign flag_set.small_ol = faults.small_ol;
   assign flag_set.strong_ol = faults.strong_ol;
   assign flag_set.lin_short_gnd = faults.lin_short_gnd;
   assign flag_set.lin_short_bat = faults.lin_short_bat;
   assign flag_set.lin_dom_timeout = faults.lin_dom_timeout;
   assign flags_d = flag_set | (diag_flags & ~{$bits(diag_flags){clear_now}});

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         diag_flags <= '0;
      end else begin
         diag_flags <= flags_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counters and status

   logic [prot_diag_pkg::restart_cnt_width-1:0] restart_d;
   logic [prot_diag_pkg::wd_fail_cnt_width-1:0] wd_d;
   logic global_d;

   // counters saturate rather than wrap so a long fault history is not hidden
   assign restart_d = (main_regulator_restart_fail && restart_fail_count != '1)
      ? restart_fail_count + 3'h1 : restart_fail_count;
   // a good kick (no failure, kick present) ends the consecutive run
   assign wd_d = (watchdog_fail_event && wd_fail_count != '1) ? wd_fail_count + 3'h1
      : (!watchdog_fail && !watchdog_kick_missing && !watchdog_fail_event) ? prot_diag_pkg::wd_fail_cnt_rst
      : wd_fail_count;
   assign global_d = (|diag_flags.small_oc) | diag_flags.strong_oc | diag_flags.supply_ov
      | diag_flags.supply_uv | faults.temp_warn | faults.thermal_one | faults.thermal_two
      | faults.main_reg_fail;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         restart_fail_count <= prot_diag_pkg::restart_cnt_rst;
         wd_fail_count <= prot_diag_pkg::wd_fail_cnt_rst;
         status_kick_q <= 1'b0;
         global_error <= 1'b0;
      end else begin
         restart_fail_count <= restart_d;
         wd_fail_count <= wd_d;
         status_kick_q <= watchdog_kick_bit;
         global_error <= global_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   property p_ov_off;
      @(posedge clock) disable iff (sys_rst)
      faults.supply_ov |=> (drive.small_hs_en == '0 && !drive.strong_hs_en && drive.relay_en == '0
         && !drive.lin_tx_en);
   endproperty
   a_ov_off: assert property (p_ov_off) else $error("outputs on during over-voltage");

   property p_uv_off;
      @(posedge clock) disable iff (sys_rst)
      faults.supply_uv |=> (drive.relay_en == '0 && !drive.lin_tx_en && !drive.strong_hs_en);
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("outputs on during under-voltage");

   property p_ov_flag_holds;
      @(posedge clock) disable iff (sys_rst)
      (diag_flags.supply_ov && !clear_now) |=> diag_flags.supply_ov;
   endproperty
   a_ov_flag_holds: assert property (p_ov_flag_holds) else $error("ov flag lost without clear");

   property p_uv_flag;
      @(posedge clock) disable iff (sys_rst)
      faults.supply_uv |=> diag_flags.supply_uv;
   endproperty
   a_uv_flag: assert property (p_uv_flag) else $error("uv flag not set");

   property p_no_recover;
      @(posedge clock) disable iff (sys_rst)
      ($fell(supply_fault) && !auto_recover && !clear_now) |-> supply_hold_q;
   endproperty
   a_no_recover: assert property (p_no_recover) else $error("outputs recovered without auto recovery");

   property p_strong_oc;
      @(posedge clock) disable iff (sys_rst)
      faults.strong_oc |=> (!drive.strong_hs_en && diag_flags.strong_oc);
   endproperty
   a_strong_oc: assert property (p_strong_oc) else $error("strong output on during over-current");

   property p_thermal;
      @(posedge clock) disable iff (sys_rst)
      (faults.thermal_one || faults.thermal_two || reset_condition) |=> drive.small_hs_en == '0;
   endproperty
   a_thermal: assert property (p_thermal) else $error("high side on in thermal shutdown");

   property p_restart;
      @(posedge clock) disable iff (sys_rst)
      (strong_trip_q && !faults.strong_oc && restart_ok && strong_hs_ctrl && !hs_block) |=> drive.strong_hs_en;
   endproperty
   a_restart: assert property (p_restart) else $error("strong output not restarted");

   property p_no_restart;
      @(posedge clock) disable iff (sys_rst)
      (strong_trip_q && !restart_ok) |=> !drive.strong_hs_en;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("strong output restarted without recovery");

   property p_wd_relay;
      @(posedge clock) disable iff (sys_rst)
      (watchdog_fail || watchdog_kick_missing) |=> drive.relay_en == 2'h0;
   endproperty
   a_wd_relay: assert property (p_wd_relay) else $error("relay on during watchdog failure");

   property p_kick;
      @(posedge clock) disable iff (sys_rst)
      ##1 status_kick_q == $past(watchdog_kick_bit);
   endproperty
   a_kick: assert property (p_kick) else $error("kick status mismatch");

   property p_global;
      @(posedge clock) disable iff (sys_rst)
      diag_flags.supply_ov |=> global_error;
   endproperty
   a_global: assert property (p_global) else $error("global error missing");

   property p_global_warn;
      @(posedge clock) disable iff (sys_rst)
      (faults.temp_warn || faults.main_reg_fail || faults.thermal_one || faults.thermal_two
         || diag_flags.supply_uv || diag_flags.strong_oc) |=> global_error;
   endproperty
   a_global_warn: assert property (p_global_warn) else $error("global error misses a fault");

   property p_strong_ol;
      @(posedge clock) disable iff (sys_rst)
      faults.strong_ol |=> diag_flags.strong_ol;
   endproperty
   a_strong_ol: assert property (p_strong_ol) else $error("strong open-load flag not set");

   // one copy per small output, so a failure names the bit that broke
   for (genvar gi = 0; gi < prot_diag_pkg::num_small_hs; gi = gi + 1) begin : g_small_chk
      property p_small_oc;
         @(posedge clock) disable iff (sys_rst)
         faults.small_oc[gi] |=> (!drive.small_hs_en[gi] && diag_flags.small_oc[gi]);
      endproperty
      a_small_oc: assert property (p_small_oc) else $error("small output on during over-current");

      property p_small_ol;
         @(posedge clock) disable iff (sys_rst)
         faults.small_ol[gi] |=> diag_flags.small_ol[gi];
      endproperty
      a_small_ol: assert property (p_small_ol) else $error("small open-load flag not set");
   end

   property p_wd_hs;
      @(posedge clock) disable iff (sys_rst)
      watchdog_fail |=> (drive.small_hs_en == '0 && !drive.strong_hs_en);
   endproperty
   a_wd_hs: assert property (p_wd_hs) else $error("high side on during watchdog failure");

   // control bits survive a watchdog failure, so the programmed state must come back
   property p_wd_resume;
      @(posedge clock) disable iff (sys_rst)
      ($fell(watchdog_fail) && !reset_condition && !supply_fault && !supply_hold_q && !faults.thermal_one
         && !faults.thermal_two && small_trip_d == '0) |=> drive.small_hs_en == $past(small_hs_ctrl);
   endproperty
   a_wd_resume: assert property (p_wd_resume) else $error("high side did not resume after watchdog");

   property p_active;
      @(posedge clock) disable iff (sys_rst)
      (strong_trip_q && !active_mode) |=> !drive.strong_hs_en;
   endproperty
   a_active: assert property (p_active) else $error("strong output restarted outside active mode");

   property p_lin_gnd;
      @(posedge clock) disable iff (sys_rst)
      faults.lin_short_gnd |=> diag_flags.lin_short_gnd;
   endproperty
   a_lin_gnd: assert property (p_lin_gnd) else $error("lin short to ground flag not set");

   property p_lin_bat;
      @(posedge clock) disable iff (sys_rst)
      faults.lin_short_bat |=> diag_flags.lin_short_bat;
   endproperty
   a_lin_bat: assert property (p_lin_bat) else $error("lin short to battery flag not set");

   property p_lin_dom;
      @(posedge clock) disable iff (sys_rst)
      faults.lin_dom_timeout |=> diag_flags.lin_dom_timeout;
   endproperty
   a_lin_dom: assert property (p_lin_dom) else $error("lin dominant timeout flag not set");

   property p_restart_cnt;
      @(posedge clock) disable iff (sys_rst)
      (main_regulator_restart_fail && restart_fail_count != '1)
         |=> restart_fail_count == $past(restart_fail_count) + 3'h1;
   endproperty
   a_restart_cnt: assert property (p_restart_cnt) else $error("restart fail count did not step");

   property p_wd_cnt;
      @(posedge clock) disable iff (sys_rst)
      (watchdog_fail_event && wd_fail_count != '1)
         |=> wd_fail_count == $past(wd_fail_count) + 3'h1;
   endproperty
   a_wd_cnt: assert property (p_wd_cnt) else $error("watchdog fail count did not step");

   property p_wd_cnt_hold;
      @(posedge clock) disable iff (sys_rst)
      (watchdog_fail && !watchdog_fail_event) |=> wd_fail_count == $past(wd_fail_count);
   endproperty
   a_wd_cnt_hold: assert property (p_wd_cnt_hold) else $error("watchdog fail count lost while failing");

   property p_flag_sticky;
      @(posedge clock) disable iff (sys_rst)
      !clear_now |=> (diag_flags & $past(diag_flags)) == $past(diag_flags);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

   property p_clear;
      @(posedge clock) disable iff (sys_rst)
      (clear_now && flag_set == '0) |=> diag_flags == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("flags not cleared by clear write");

   c_ov_event: cover property (@(posedge clock) disable iff (sys_rst) $rose(faults.supply_ov));
   c_restart: cover property (@(posedge clock) disable iff (sys_rst)
      strong_trip_q && restart_ok ##1 drive.strong_hs_en);
   c_clear: cover property (@(posedge clock) disable iff (sys_rst) clear_now && diag_flags.supply_ov);
   c_wd_fail: cover property (@(posedge clock) disable iff (sys_rst) watchdog_fail_event && wd_fail_count == '1);
   c_auto_recover: cover property (@(posedge clock) disable iff (sys_rst) $fell(supply_fault) && auto_recover);

endmodule : output_protection_diag

/* File: rtl/prot_diag_pkg.sv */
// package for the protection and diagnosis block: field positions, widths, port groups
// assumes the spi block decodes frames and hands over register bits as plain signals
package prot_diag_pkg;

   localparam int unsigned num_small_hs = 4;
   localparam int unsigned auto_recovery_bit = 4;
   localparam int unsigned kick_bit_pos = 16;
   localparam int unsigned restart_cnt_width = 3;
   localparam int unsigned wd_fail_cnt_width = 3;
   localparam logic [restart_cnt_width-1:0] restart_cnt_rst = 3'h0;
   localparam logic [wd_fail_cnt_width-1:0] wd_fail_cnt_rst = 3'h0;
   localparam logic [num_small_hs-1:0] small_hs_off = 4'h0;

   // fault inputs from the analog comparators, already synchronised
   typedef struct packed {
      logic supply_ov;
      logic supply_uv;
      logic thermal_one;
      logic thermal_two;
      logic main_reg_fail;
      logic temp_warn;
      logic [num_small_hs-1:0] small_oc;
      logic strong_oc;
      logic [num_small_hs-1:0] small_ol;
      logic strong_ol;
      logic lin_short_gnd;
      logic lin_short_bat;
      logic lin_dom_timeout;
   } fault_in_t;

   // latched diagnosis flags presented to the status registers
   typedef struct packed {
      logic supply_ov;
      logic supply_uv;
      logic [num_small_hs-1:0] small_oc;
      logic strong_oc;
      logic [num_small_hs-1:0] small_ol;
      logic strong_ol;
      logic lin_short_gnd;
      logic lin_short_bat;
      logic lin_dom_timeout;
   } diag_flags_t;

   // driver enables toward the output stages
   typedef struct packed {
      logic [num_small_hs-1:0] small_hs_en;
      logic strong_hs_en;
      logic [1:0] relay_en;
      logic lin_tx_en;
   } drive_t;

endpackage : prot_diag_pkg
